// file: rtl/sgpc_defines.svh
// Register offsets, field positions, reset values and timing counts for the
// sensor gain and phase compensation datapath.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SGPC_DEFINES_SVH
`define SGPC_DEFINES_SVH

// ============================================================================
// Register offsets (word addresses on the 8-bit register port)
// ============================================================================
`define SGPC_ADDR_CAL_IGAIN   8'h00
`define SGPC_ADDR_CAL_UGAIN   8'h04
`define SGPC_ADDR_CAL_DELAY   8'h08
`define SGPC_ADDR_TEMP_SLOPE  8'h0c
`define SGPC_ADDR_UPPER_THR   8'h10
`define SGPC_ADDR_LOWER_THR   8'h11
`define SGPC_ADDR_NOM_FREQ    8'h12
`define SGPC_ADDR_NOM_TEMP    8'h13
`define SGPC_ADDR_FREQ_SLOPE  8'h14
`define SGPC_ADDR_IGAIN_SLOPE 8'h20
`define SGPC_ADDR_DELAY_SLOPE 8'h30
`define SGPC_ADDR_IGAIN_STAT  8'h40
`define SGPC_ADDR_UGAIN_STAT  8'h44
`define SGPC_ADDR_DELAY_STAT  8'h48
`define SGPC_ADDR_AVG_STAT    8'h4c

// ============================================================================
// Field positions
// ============================================================================
`define SGPC_SLOPE_MSB        7
`define SGPC_PHASE_STRIDE     4
`define SGPC_IGAIN_SHIFT      19
`define SGPC_UGAIN_SHIFT      20
`define SGPC_FREQ_SHIFT       9
`define SGPC_CURR_SHIFT       8

// ============================================================================
// Reset values
// ============================================================================
`define SGPC_GAIN_RST         16'h4000
`define SGPC_ZERO_RST         16'h0000

// ============================================================================
// Timing
// ============================================================================
`define SGPC_CLK_PERIOD_NS    25
`define SGPC_SAMPLE_PERIOD_NS 125000
`define SGPC_AVG_LOG2         13

`endif

// file: rtl/sgpc_pkg.sv
// Types shared by the sensor gain and phase compensation datapath.
// Assumes nothing of its surroundings.
package sgpc_pkg;

  typedef enum logic {
    SGPC_ST_IDLE,
    SGPC_ST_CALC
  } sgpc_state_t;

  typedef logic [2:0][15:0] sgpc_word3_t;
  typedef logic [2:0][2:0][7:0] sgpc_slope3_t;

  typedef struct packed {
    sgpc_state_t       st;
    logic [1:0]        ph;
    logic [12:0]       tick_cnt;
    logic [12:0]       avg_cnt;
    sgpc_word3_t       cal_igain;
    sgpc_word3_t       cal_ugain;
    sgpc_word3_t       cal_delay;
    sgpc_word3_t       temp_slope;
    sgpc_slope3_t      igain_slope;
    sgpc_slope3_t      delay_slope;
    logic [15:0]       upper_thr;
    logic [15:0]       lower_thr;
    logic [15:0]       nom_freq;
    logic [15:0]       nom_temp;
    logic [15:0]       freq_slope;
    sgpc_word3_t       irms;
    logic [15:0]       freq;
    logic [15:0]       temp;
    sgpc_word3_t       igain;
    sgpc_word3_t       ugain;
    sgpc_word3_t       delay_out;
    logic [2:0][31:0]  delay_acc;
    logic [15:0]       rdata;
  } sgpc_regs_t;

endpackage : sgpc_pkg

// file: rtl/sgpc_log16.sv
// Sixteen times the base-two logarithm of an unsigned 16-bit value.
// Purely combinational; the caller registers the result where needed.
`timescale 1ns/1ps

module sgpc_log16 (
  input  wire logic [15:0] value_i,
  output logic      [7:0]  log_o
);

  logic [3:0]  msb;
  logic [15:0] norm;

  // Integer part is the leading-one index, fraction the four bits below it.
  always_comb begin
    msb = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (value_i[i]) begin
        msb = 4'(i);
      end
    end
    norm  = value_i << (4'hf - msb);
    log_o = {msb, norm[14:11]};
  end

endmodule : sgpc_log16

// file: rtl/sgpc_top.sv
// Sensor gain and phase compensation datapath for three metering phases.
// Assumes measurements and register strobes come from logic on sys_clk_i.
`timescale 1ns/1ps
`include "sgpc_defines.svh"

module sgpc_top #(
  parameter int SAMPLE_CYCLES = `SGPC_SAMPLE_PERIOD_NS / `SGPC_CLK_PERIOD_NS,
  parameter int AVG_LOG2      = `SGPC_AVG_LOG2
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [15:0] irms_a_i,
  input  wire logic [15:0] irms_b_i,
  input  wire logic [15:0] irms_c_i,
  input  wire logic [15:0] line_freq_i,
  input  wire logic [15:0] temperature_i,
  output logic      [15:0] current_gain_a_o,
  output logic      [15:0] current_gain_b_o,
  output logic      [15:0] current_gain_c_o,
  output logic      [15:0] voltage_gain_a_o,
  output logic      [15:0] voltage_gain_b_o,
  output logic      [15:0] voltage_gain_c_o,
  output logic      [15:0] channel_delay_a_o,
  output logic      [15:0] channel_delay_b_o,
  output logic      [15:0] channel_delay_c_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] sat16(input logic signed [63:0] v);
    if (v < 64'sd0) begin
      return 16'h0000;
    end else if (v > 64'sd65535) begin
      return 16'hffff;
    end
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [7:0] slope_pick(
    input logic [2:0][7:0] s,
    input logic [1:0]      seg
  );
    return $signed(s[seg]);
  endfunction : slope_pick

  // ==========================================================================
  // State
  // ==========================================================================
  sgpc_pkg::sgpc_regs_t s_q;
  sgpc_pkg::sgpc_regs_t s_d;

  logic [15:0]        irms_sel;
  logic [2:0][15:0]   log_in;
  logic [2:0][7:0]    log_out;
  logic [1:0]         seg;
  logic signed [8:0]  dlog;
  logic signed [8:0]  lratio;
  logic signed [63:0] g0;
  logic signed [63:0] u0;
  logic signed [63:0] g_term;
  logic signed [63:0] igain_calc;
  logic signed [63:0] ugain_calc;
  logic signed [63:0] phi_calc;
  logic signed [16:0] tdiff;
  logic signed [16:0] fdiff;
  logic [15:0]        phi_sat;
  logic [31:0]        acc_new;
  logic               tick;
  logic               avg_last;

  assign tick     = s_q.tick_cnt == 13'(SAMPLE_CYCLES - 1);
  assign avg_last = s_q.avg_cnt == 13'((1 << AVG_LOG2) - 1);
  assign irms_sel = s_q.irms[s_q.ph];

  // ==========================================================================
  // Logarithms of current and thresholds
  // ==========================================================================
  assign log_in = {s_q.lower_thr, s_q.upper_thr, irms_sel};

  for (genvar k = 0; k < 3; k++) begin : g_log
    sgpc_log16 u_log (
      .value_i (log_in[k]),
      .log_o   (log_out[k])
    );
  end

  // ==========================================================================
  // Segment selection and compensation arithmetic
  // ==========================================================================
  always_comb begin
    if (irms_sel > s_q.upper_thr) begin
      seg = 2'd0;
    end else if (irms_sel > s_q.lower_thr) begin
      seg = 2'd1;
    end else begin
      seg = 2'd2;
    end
  end

  // Log ratio of current to segment reference, and of lower to upper.
  assign dlog = $signed({1'b0, log_out[0]}) -
                $signed({1'b0, (seg == 2'd2) ? log_out[2] : log_out[1]});
  assign lratio = $signed({1'b0, log_out[2]}) - $signed({1'b0, log_out[1]});

  assign g0 = $signed({48'h0, s_q.cal_igain[s_q.ph]});
  assign u0 = $signed({48'h0, s_q.cal_ugain[s_q.ph]});

  // Current gain: slope term plus continuity offset, both over 2^19.
  assign g_term =
    64'(slope_pick(s_q.igain_slope[s_q.ph], seg) * dlog) +
    ((seg == 2'd2) ?
      64'(slope_pick(s_q.igain_slope[s_q.ph], 2'd1) * lratio) :
      64'sd0);
  assign igain_calc = g0 + ((g0 * g_term) >>> `SGPC_IGAIN_SHIFT);

  // Voltage gain follows temperature only.
  assign tdiff = $signed(s_q.temp) - $signed(s_q.nom_temp);
  assign ugain_calc = u0 +
    ((u0 * 64'($signed(s_q.temp_slope[s_q.ph]) * tdiff))
      >>> `SGPC_UGAIN_SHIFT);

  // Delay in 2.048 MHz cycles: frequency and current terms added.
  assign fdiff = $signed({1'b0, s_q.freq}) - $signed({1'b0, s_q.nom_freq});
  assign phi_calc = $signed({48'h0, s_q.cal_delay[s_q.ph]}) +
    (64'($signed(s_q.freq_slope) * fdiff) >>> `SGPC_FREQ_SHIFT) +
    (64'(slope_pick(s_q.delay_slope[s_q.ph], seg) * dlog)
      >>> `SGPC_CURR_SHIFT) +
    ((seg == 2'd2) ?
      (64'(slope_pick(s_q.delay_slope[s_q.ph], 2'd1) * lratio)
        >>> `SGPC_CURR_SHIFT) : 64'sd0);

  assign phi_sat = sat16(phi_calc);
  assign acc_new = s_q.delay_acc[s_q.ph] + {16'h0000, phi_sat};

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 16'h0000;
    s_d.tick_cnt = tick ? 13'h0000 : s_q.tick_cnt + 13'h0001;

    case (s_q.st)
      sgpc_pkg::SGPC_ST_IDLE: begin
        if (tick) begin
          s_d.irms = {irms_c_i, irms_b_i, irms_a_i};
          s_d.freq = line_freq_i;
          s_d.temp = temperature_i;
          s_d.ph   = 2'd0;
          s_d.st   = sgpc_pkg::SGPC_ST_CALC;
        end
      end
      sgpc_pkg::SGPC_ST_CALC: begin
        s_d.igain[s_q.ph] = sat16(igain_calc);
        s_d.ugain[s_q.ph] = sat16(ugain_calc);
        if (avg_last) begin
          s_d.delay_out[s_q.ph] = 16'(acc_new >> AVG_LOG2);
          s_d.delay_acc[s_q.ph] = 32'h0000_0000;
        end else begin
          s_d.delay_acc[s_q.ph] = acc_new;
        end
        if (s_q.ph == 2'd2) begin
          s_d.st      = sgpc_pkg::SGPC_ST_IDLE;
          s_d.avg_cnt = avg_last ? 13'h0000 : s_q.avg_cnt + 13'h0001;
        end else begin
          s_d.ph = s_q.ph + 2'd1;
        end
      end
      default: begin
        s_d.st = sgpc_pkg::SGPC_ST_IDLE;
      end
    endcase

    if (reg_wr_i) begin
      for (int p = 0; p < 3; p++) begin
        if (reg_addr_i == `SGPC_ADDR_CAL_IGAIN + 8'(p)) begin
          s_d.cal_igain[p] = reg_wdata_i;
        end else if (reg_addr_i == `SGPC_ADDR_CAL_UGAIN + 8'(p)) begin
          s_d.cal_ugain[p] = reg_wdata_i;
        end else if (reg_addr_i == `SGPC_ADDR_CAL_DELAY + 8'(p)) begin
          s_d.cal_delay[p] = reg_wdata_i;
        end else if (reg_addr_i == `SGPC_ADDR_TEMP_SLOPE + 8'(p)) begin
          s_d.temp_slope[p] = reg_wdata_i;
        end
        for (int g = 0; g < 3; g++) begin
          if (reg_addr_i == `SGPC_ADDR_IGAIN_SLOPE +
              8'(p * `SGPC_PHASE_STRIDE + g)) begin
            s_d.igain_slope[p][g] = reg_wdata_i[`SGPC_SLOPE_MSB:0];
          end else if (reg_addr_i == `SGPC_ADDR_DELAY_SLOPE +
                       8'(p * `SGPC_PHASE_STRIDE + g)) begin
            s_d.delay_slope[p][g] = reg_wdata_i[`SGPC_SLOPE_MSB:0];
          end
        end
      end
      if (reg_addr_i == `SGPC_ADDR_UPPER_THR) begin
        s_d.upper_thr = reg_wdata_i;
      end else if (reg_addr_i == `SGPC_ADDR_LOWER_THR) begin
        s_d.lower_thr = reg_wdata_i;
      end else if (reg_addr_i == `SGPC_ADDR_NOM_FREQ) begin
        s_d.nom_freq = reg_wdata_i;
      end else if (reg_addr_i == `SGPC_ADDR_NOM_TEMP) begin
        s_d.nom_temp = reg_wdata_i;
      end else if (reg_addr_i == `SGPC_ADDR_FREQ_SLOPE) begin
        s_d.freq_slope = reg_wdata_i;
      end
    end

    if (reg_rd_i) begin
      for (int p = 0; p < 3; p++) begin
        if (reg_addr_i == `SGPC_ADDR_CAL_IGAIN + 8'(p)) begin
          s_d.rdata = s_q.cal_igain[p];
        end else if (reg_addr_i == `SGPC_ADDR_CAL_UGAIN + 8'(p)) begin
          s_d.rdata = s_q.cal_ugain[p];
        end else if (reg_addr_i == `SGPC_ADDR_CAL_DELAY + 8'(p)) begin
          s_d.rdata = s_q.cal_delay[p];
        end else if (reg_addr_i == `SGPC_ADDR_TEMP_SLOPE + 8'(p)) begin
          s_d.rdata = s_q.temp_slope[p];
        end else if (reg_addr_i == `SGPC_ADDR_IGAIN_STAT + 8'(p)) begin
          s_d.rdata = s_q.igain[p];
        end else if (reg_addr_i == `SGPC_ADDR_UGAIN_STAT + 8'(p)) begin
          s_d.rdata = s_q.ugain[p];
        end else if (reg_addr_i == `SGPC_ADDR_DELAY_STAT + 8'(p)) begin
          s_d.rdata = s_q.delay_out[p];
        end
        for (int g = 0; g < 3; g++) begin
          if (reg_addr_i == `SGPC_ADDR_IGAIN_SLOPE +
              8'(p * `SGPC_PHASE_STRIDE + g)) begin
            s_d.rdata = {8'h00, s_q.igain_slope[p][g]};
          end else if (reg_addr_i == `SGPC_ADDR_DELAY_SLOPE +
                       8'(p * `SGPC_PHASE_STRIDE + g)) begin
            s_d.rdata = {8'h00, s_q.delay_slope[p][g]};
          end
        end
      end
      if (reg_addr_i == `SGPC_ADDR_UPPER_THR) begin
        s_d.rdata = s_q.upper_thr;
      end else if (reg_addr_i == `SGPC_ADDR_LOWER_THR) begin
        s_d.rdata = s_q.lower_thr;
      end else if (reg_addr_i == `SGPC_ADDR_NOM_FREQ) begin
        s_d.rdata = s_q.nom_freq;
      end else if (reg_addr_i == `SGPC_ADDR_NOM_TEMP) begin
        s_d.rdata = s_q.nom_temp;
      end else if (reg_addr_i == `SGPC_ADDR_FREQ_SLOPE) begin
        s_d.rdata = s_q.freq_slope;
      end else if (reg_addr_i == `SGPC_ADDR_AVG_STAT) begin
        s_d.rdata = {3'h0, s_q.avg_cnt};
      end
    end

    if (sys_rst_i) begin
      s_d           = '0;
      s_d.st        = sgpc_pkg::SGPC_ST_IDLE;
      s_d.cal_igain = {3{`SGPC_GAIN_RST}};
      s_d.cal_ugain = {3{`SGPC_GAIN_RST}};
      s_d.cal_delay = {3{`SGPC_ZERO_RST}};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_q <= s_d;
  end

  assign reg_rdata_o       = s_q.rdata;
  assign current_gain_a_o  = s_q.igain[0];
  assign current_gain_b_o  = s_q.igain[1];
  assign current_gain_c_o  = s_q.igain[2];
  assign voltage_gain_a_o  = s_q.ugain[0];
  assign voltage_gain_b_o  = s_q.ugain[1];
  assign voltage_gain_c_o  = s_q.ugain[2];
  assign channel_delay_a_o = s_q.delay_out[0];
  assign channel_delay_b_o = s_q.delay_out[1];
  assign channel_delay_c_o = s_q.delay_out[2];

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic calc;
  assign calc = s_q.st == sgpc_pkg::SGPC_ST_CALC;

  AST_LOG_TWO: assert property (
    (s_q.upper_thr == 16'h0002) |-> (log_out[1] == 8'h10))
    else $error("log of two is not sixteen");
  AST_SEG_UPPER: assert property (
    (calc && irms_sel > s_q.upper_thr) |-> (seg == 2'd0))
    else $error("upper segment not chosen");
  AST_SEG_LOWER: assert property (
    (calc && irms_sel <= s_q.lower_thr && irms_sel <= s_q.upper_thr)
      |-> (seg == 2'd2))
    else $error("lower segment not chosen");
  AST_START: assert property (
    (tick && !calc) |=> (calc && s_q.ph == 2'd0))
    else $error("sample tick did not start evaluation");
  AST_CALC_LEN: assert property (
    (calc && s_q.ph == 2'd0) |=> calc ##1 (calc && s_q.ph == 2'd2)
      ##1 !calc)
    else $error("evaluation is not three cycles");
  AST_HOLD_DELAY: assert property (
    !(calc && avg_last) |=> $stable(s_q.delay_out))
    else $error("applied delay changed between updates");
  AST_IGAIN_NOM: assert property (
    (calc && seg != 2'd2 && dlog == 9'sd0)
      |=> (s_q.igain[$past(s_q.ph)] == $past(s_q.cal_igain[s_q.ph])))
    else $error("current gain not nominal at reference");
  AST_UGAIN_NOM: assert property (
    (calc && s_q.temp == s_q.nom_temp)
      |=> (s_q.ugain[$past(s_q.ph)] == $past(s_q.cal_ugain[s_q.ph])))
    else $error("voltage gain not nominal at reference temperature");
  AST_PHI_NOM: assert property (
    (calc && seg != 2'd2 && dlog == 9'sd0 && s_q.freq == s_q.nom_freq)
      |-> (phi_sat == s_q.cal_delay[s_q.ph]))
    else $error("delay not nominal at reference point");
  AST_RD_IDLE: assert property (
    !reg_rd_i |=> (reg_rdata_o == 16'h0000))
    else $error("read data outside read answer cycle");

  COV_TICK:   cover property (tick ##1 calc);
  COV_SEG2:   cover property (calc && seg == 2'd2);
  COV_APPLY:  cover property (calc && avg_last && s_q.ph == 2'd2);
  COV_RDWR:   cover property (reg_wr_i ##1 reg_rd_i);

endmodule : sgpc_top

// file: dv/sgpc_tb.sv
// Self-checking testbench for the sensor gain and phase compensation block.
// Assumes rtl/ is on the include path and the design files compile first.
`timescale 1ns/1ps
`include "sgpc_defines.svh"

module testbench;
  localparam int SC = 16;
  localparam int AL = 2;

  logic        sys_clk_i;
  logic        sys_rst_i;
  logic [7:0]  reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic [15:0] irms_a_i, irms_b_i, irms_c_i;
  logic [15:0] line_freq_i;
  logic [15:0] temperature_i;
  logic [15:0] current_gain_a_o, current_gain_b_o, current_gain_c_o;
  logic [15:0] voltage_gain_a_o, voltage_gain_b_o, voltage_gain_c_o;
  logic [15:0] channel_delay_a_o, channel_delay_b_o, channel_delay_c_o;
  int          fail_count;
  int          checks_done;
  int          cyc;
  int          gap;
  logic [15:0] last_d;
  logic        mon_en;
  logic        viol;

  sgpc_top #(.SAMPLE_CYCLES(SC), .AVG_LOG2(AL)) i_dut (
    .sys_clk_i        (sys_clk_i),
    .sys_rst_i        (sys_rst_i),
    .reg_addr_i       (reg_addr_i),
    .reg_wdata_i      (reg_wdata_i),
    .reg_wr_i         (reg_wr_i),
    .reg_rd_i         (reg_rd_i),
    .reg_rdata_o      (reg_rdata_o),
    .irms_a_i         (irms_a_i),
    .irms_b_i         (irms_b_i),
    .irms_c_i         (irms_c_i),
    .line_freq_i      (line_freq_i),
    .temperature_i    (temperature_i),
    .current_gain_a_o (current_gain_a_o),
    .current_gain_b_o (current_gain_b_o),
    .current_gain_c_o (current_gain_c_o),
    .voltage_gain_a_o (voltage_gain_a_o),
    .voltage_gain_b_o (voltage_gain_b_o),
    .voltage_gain_c_o (voltage_gain_c_o),
    .channel_delay_a_o(channel_delay_a_o),
    .channel_delay_b_o(channel_delay_b_o),
    .channel_delay_c_o(channel_delay_c_o)
  );

  // ==========================================================================
  // Clock, timeout and hold monitor
  // ==========================================================================
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end

  // The applied delay must not move faster than once per averaging window.
  always @(posedge sys_clk_i) begin
    if (mon_en && channel_delay_a_o !== last_d && gap < SC * (1 << AL)) begin
      viol <= 1'b1;
    end
    if (channel_delay_a_o !== last_d) begin
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
    last_d <= channel_delay_a_o;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask : rd

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    gap = 1000;
    last_d = 16'h0000;
    mon_en = 1'b0;
    viol = 1'b0;
    sys_rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    irms_a_i = 16'h0200;
    irms_b_i = 16'h0080;
    irms_c_i = 16'h0020;
    line_freq_i = 16'h0034;
    temperature_i = 16'h0023;
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check(current_gain_a_o, 16'h0000);
    check(channel_delay_a_o, 16'h0000);
    rd(`SGPC_ADDR_CAL_IGAIN, 16'h4000);
    rd(`SGPC_ADDR_CAL_UGAIN + 8'h02, 16'h4000);
    rd(`SGPC_ADDR_CAL_DELAY, 16'h0000);
    rd(8'h7f, 16'h0000);
    wr(`SGPC_ADDR_IGAIN_SLOPE, 16'hff40);
    rd(`SGPC_ADDR_IGAIN_SLOPE, 16'h0040);
    @(posedge sys_clk_i);
    #1;
    check(reg_rdata_o, 16'h0000);
    // An upper threshold of two briefly exercises the log-of-two check.
    wr(`SGPC_ADDR_UPPER_THR, 16'h0002);
    rd(`SGPC_ADDR_UPPER_THR, 16'h0002);
    // Thresholds: upper log 128, lower log 96.
    wr(`SGPC_ADDR_UPPER_THR, 16'h0100);
    wr(`SGPC_ADDR_LOWER_THR, 16'h0040);
    wr(`SGPC_ADDR_NOM_FREQ, 16'h0032);
    wr(`SGPC_ADDR_FREQ_SLOPE, 16'h0100);
    wr(`SGPC_ADDR_NOM_TEMP, 16'h0019);
    wr(`SGPC_ADDR_TEMP_SLOPE, 16'h0040);
    wr(`SGPC_ADDR_TEMP_SLOPE + 8'h01, 16'hffc0);
    wr(`SGPC_ADDR_CAL_DELAY, 16'h0100);
    wr(`SGPC_ADDR_CAL_DELAY + 8'h01, 16'h0100);
    wr(`SGPC_ADDR_CAL_DELAY + 8'h02, 16'h0100);
    wr(`SGPC_ADDR_IGAIN_SLOPE + 8'h05, 16'h0040);
    wr(`SGPC_ADDR_IGAIN_SLOPE + 8'h09, 16'h0040);
    wr(`SGPC_ADDR_IGAIN_SLOPE + 8'h0a, 16'h0040);
    wr(`SGPC_ADDR_DELAY_SLOPE, 16'h0040);
    wr(`SGPC_ADDR_DELAY_SLOPE + 8'h05, 16'h0040);
    wr(`SGPC_ADDR_DELAY_SLOPE + 8'h09, 16'h0040);
    wr(`SGPC_ADDR_DELAY_SLOPE + 8'h0a, 16'h0040);
    repeat (260) @(posedge sys_clk_i);
    #1;
    check(current_gain_a_o, 16'h4020);
    check(current_gain_b_o, 16'h3fe0);
    check(current_gain_c_o, 16'h3fa0);
    check(voltage_gain_a_o, 16'h400a);
    check(voltage_gain_b_o, 16'h3ff6);
    check(voltage_gain_c_o, 16'h4000);
    check(channel_delay_a_o, 16'h0105);
    check(channel_delay_b_o, 16'h00fd);
    check(channel_delay_c_o, 16'h00f5);
    rd(`SGPC_ADDR_IGAIN_STAT, 16'h4020);
    wr(`SGPC_ADDR_IGAIN_STAT, 16'h1234);
    rd(`SGPC_ADDR_IGAIN_STAT, 16'h4020);
    rd(`SGPC_ADDR_DELAY_STAT, 16'h0105);
    // Move current and frequency together; gains follow each sample.
    mon_en <= 1'b1;
    irms_a_i <= 16'h0400;
    irms_b_i <= 16'h0100;
    line_freq_i <= 16'h0036;
    repeat (SC + 6) @(posedge sys_clk_i);
    #1;
    check(current_gain_a_o, 16'h4040);
    check(current_gain_b_o, 16'h4000);
    check(current_gain_c_o, 16'h3fa0);
    check(voltage_gain_a_o, 16'h400a);
    repeat (300) @(posedge sys_clk_i);
    #1;
    check({15'h0000, viol}, 16'h0000);
    check(channel_delay_a_o, 16'h010a);
    check(channel_delay_b_o, 16'h0102);
    check(channel_delay_c_o, 16'h00f6);
    // Temperature and frequency at nominal; phase B sits at its reference.
    temperature_i <= 16'h0019;
    line_freq_i <= 16'h0032;
    repeat (SC + 6) @(posedge sys_clk_i);
    #1;
    check(voltage_gain_a_o, 16'h4000);
    check(voltage_gain_b_o, 16'h4000);
    check(current_gain_b_o, 16'h4000);
    repeat (150) @(posedge sys_clk_i);
    #1;
    check(channel_delay_a_o, 16'h0108);
    check(channel_delay_b_o, 16'h0100);
    check({15'h0000, viol}, 16'h0000);
    final_report();
  end
endmodule : testbench
